/* File: gbx_pkg.sv */
package gbx_pkg;

    // Register indexes; byte address is four times the index
    localparam logic [15:0] IDX_EXT_CAP = 16'h200f;
    localparam logic [15:0] IDX_TMR_MODE = 16'ha000;
    localparam logic [15:0] IDX_IRQ_EN = 16'ha001;
    localparam logic [15:0] IDX_IRQ_STS = 16'ha002;
    localparam logic [31:0] ADDR_EXT_CAP = {14'h0000, IDX_EXT_CAP, 2'h0};
    localparam logic [31:0] ADDR_TMR_MODE = {14'h0000, IDX_TMR_MODE, 2'h0};
    localparam logic [31:0] ADDR_IRQ_EN = {14'h0000, IDX_IRQ_EN, 2'h0};
    localparam logic [31:0] ADDR_IRQ_STS = {14'h0000, IDX_IRQ_STS, 2'h0};

    localparam logic [15:0] EXT_CAP_VALUE = 16'h8000;

    localparam int TMR_SEL_LO = 14;
    localparam int TMR_BYPASS_BIT = 13;
    localparam int TMR_RSVD_BIT = 1;
    localparam int TMR_NOISE_BIT = 0;
    localparam int IRQ_LO_BIT = 7;
    localparam int IRQ_N = 8;

    localparam logic [1:0] TMR_SEL_RST = 2'h0;
    localparam logic BYPASS_RST = 1'h1;
    localparam logic NOISE_RST = 1'h0;
    localparam logic RSVD1_RST = 1'h0;
    localparam logic [15:0] IRQ_EN_RST = 16'h0000;
    localparam logic [IRQ_N-1:0] IRQ_STS_RST = 8'h00;

    localparam real CLK_MHZ = 125.0;
    localparam real LT_SEL0_MS = 1.6;
    localparam real LT_SEL1_US = 0.5;
    localparam real LT_SEL2_US = 1.0;
    localparam real LT_SEL3_US = 2.0;
    localparam logic [17:0] LT_1P6MS_CYC = 18'(int'($ceil(LT_SEL0_MS * 1000.0 * CLK_MHZ)));
    localparam logic [17:0] LT_0P5US_CYC = 18'(int'($ceil(LT_SEL1_US * CLK_MHZ)));
    localparam logic [17:0] LT_1US_CYC = 18'(int'($ceil(LT_SEL2_US * CLK_MHZ)));
    localparam logic [17:0] LT_2US_CYC = 18'(int'($ceil(LT_SEL3_US * CLK_MHZ)));

    typedef enum logic [1:0] {
        LT_SEL_1P6MS = 2'b00,
        LT_SEL_0P5US = 2'b01,
        LT_SEL_1US = 2'b10,
        LT_SEL_2US = 2'b11
    } gbx_lt_sel_e;

    typedef struct packed {
        logic [1:0] speed;
        logic duplex;
        logic page_rx;
        logic an_done;
        logic link_up;
        logic sym_err;
        logic false_carrier;
    } gbx_pcs_s;

    typedef struct packed {
        gbx_lt_sel_e timer_sel;
        logic bypass_allow;
        logic noise_filter;
    } gbx_ctrl_s;

endpackage

/* File: gbx_serial_regs.sv */
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module gbx_serial_regs
    import gbx_pkg::*;
#(
    parameter logic [17:0] LT_LONG_CYC = LT_1P6MS_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sw_rst,
    input wire gbx_pcs_s pcs,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output gbx_ctrl_s ctrl,
    output logic [17:0] link_timer_cyc,
    output logic irq
);

    logic setup;
    logic access;
    logic wr_tmr;
    logic wr_en;
    logic rd_sts;

    gbx_lt_sel_e tsel_q, tsel_d;
    logic byp_cfg_q, byp_cfg_d;
    logic byp_act_q, byp_act_d;
    logic rsv1_q, rsv1_d;
    logic noise_q, noise_d;
    logic [15:0] ien_q, ien_d;

    logic [31:0] rdat_q, rdat_d;
    logic err_q, err_d;
    logic hit_sts_q, hit_sts_d;

    logic [1:0] spd_prev_q, spd_prev_d;
    logic dup_prev_q, dup_prev_d;
    logic link_prev_q, link_prev_d;

    logic [IRQ_N-1:0] evt;
    logic [IRQ_N-1:0] rd_clr;
    logic [IRQ_N-1:0] sts_q, sts_d;

    logic [17:0] lt_q, lt_d;
    logic irq_q, irq_d;

    // Slave answers with no wait states
    assign pready = 1'b1;
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign pslverr = access & err_q;
    assign prdata = rdat_q;

    assign wr_tmr = access & pwrite & (paddr == ADDR_TMR_MODE);
    assign wr_en = access & pwrite & (paddr == ADDR_IRQ_EN);
    assign rd_sts = access & ~pwrite & hit_sts_q;

    // Read data captured in setup so the access edge only clears what was shown
    always_comb begin
        rdat_d = rdat_q;
        err_d = err_q;
        hit_sts_d = hit_sts_q;
        if (setup) begin
            rdat_d = 32'h0000_0000;
            err_d = 1'b0;
            hit_sts_d = 1'b0;
            if (paddr == ADDR_EXT_CAP) begin
                rdat_d[15:0] = EXT_CAP_VALUE;
            end else if (paddr == ADDR_TMR_MODE) begin
                rdat_d[TMR_SEL_LO +: 2] = tsel_q;
                rdat_d[TMR_BYPASS_BIT] = byp_cfg_q;
                rdat_d[TMR_RSVD_BIT] = rsv1_q;
                rdat_d[TMR_NOISE_BIT] = noise_q;
            end else if (paddr == ADDR_IRQ_EN) begin
                rdat_d[15:0] = ien_q;
            end else if (paddr == ADDR_IRQ_STS) begin
                rdat_d[IRQ_LO_BIT +: IRQ_N] = sts_q;
                hit_sts_d = 1'b1;
            end else begin
                err_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdat_q <= 32'h0000_0000;
            err_q <= 1'b0;
            hit_sts_q <= 1'b0;
        end else begin
            rdat_q <= rdat_d;
            err_q <= err_d;
            hit_sts_q <= hit_sts_d;
        end
    end

    // Control bits survive software reset, except the live bypass, which loads the configured bit; only hardware reset restores them
    always_comb begin
        tsel_d = tsel_q;
        byp_cfg_d = byp_cfg_q;
        byp_act_d = byp_act_q;
        rsv1_d = rsv1_q;
        noise_d = noise_q;
        ien_d = ien_q;
        if (wr_tmr) begin
            tsel_d = gbx_lt_sel_e'(pwdata[TMR_SEL_LO +: 2]);
            byp_cfg_d = pwdata[TMR_BYPASS_BIT];
            rsv1_d = pwdata[TMR_RSVD_BIT];
            noise_d = pwdata[TMR_NOISE_BIT];
        end
        if (wr_en) begin
            // Reserved enables stored as written; software keeps them zero
            ien_d = pwdata[15:0];
        end
        // Disruptive change, so the live bypass follows only at software reset
        if (sw_rst) begin
            byp_act_d = byp_cfg_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tsel_q <= LT_SEL_1P6MS;
            byp_cfg_q <= BYPASS_RST;
            byp_act_q <= BYPASS_RST;
            rsv1_q <= RSVD1_RST;
            noise_q <= NOISE_RST;
            ien_q <= IRQ_EN_RST;
        end else begin
            tsel_q <= tsel_d;
            byp_cfg_q <= byp_cfg_d;
            byp_act_q <= byp_act_d;
            rsv1_q <= rsv1_d;
            noise_q <= noise_d;
            ien_q <= ien_d;
        end
    end

    assign ctrl.timer_sel = tsel_q;
    assign ctrl.bypass_allow = byp_act_q;
    assign ctrl.noise_filter = noise_q;

    // Link timer length in clock cycles
    always_comb begin
        case (tsel_q)
            LT_SEL_1P6MS: lt_d = LT_LONG_CYC;
            LT_SEL_0P5US: lt_d = LT_0P5US_CYC;
            LT_SEL_1US: lt_d = LT_1US_CYC;
            LT_SEL_2US: lt_d = LT_2US_CYC;
            default: lt_d = LT_LONG_CYC;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lt_q <= LT_LONG_CYC;
        end else begin
            lt_q <= lt_d;
        end
    end

    assign link_timer_cyc = lt_q;

    // Previous values for change and edge detection
    always_comb begin
        spd_prev_d = pcs.speed;
        dup_prev_d = pcs.duplex;
        link_prev_d = pcs.link_up;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            spd_prev_q <= 2'h0;
            dup_prev_q <= 1'b0;
            link_prev_q <= 1'b0;
        end else begin
            spd_prev_q <= spd_prev_d;
            dup_prev_q <= dup_prev_d;
            link_prev_q <= link_prev_d;
        end
    end

    // Event vector, entry i lands on status bit i+7
    always_comb begin
        evt[0] = pcs.false_carrier;
        evt[1] = pcs.sym_err;
        evt[2] = pcs.link_up & ~link_prev_q;
        evt[3] = ~pcs.link_up & link_prev_q;
        evt[4] = pcs.an_done;
        evt[5] = pcs.page_rx;
        evt[6] = pcs.duplex ^ dup_prev_q;
        evt[7] = pcs.speed != spd_prev_q;
    end

    // Clear only bits the reader actually saw
    assign rd_clr = {IRQ_N{rd_sts}} & rdat_q[IRQ_LO_BIT +: IRQ_N];

    // An event in the clearing cycle wins over read or software reset
    for (genvar i = 0; i < IRQ_N; i++) begin : g_sts
        always_comb begin
            sts_d[i] = evt[i] | (sts_q[i] & ~rd_clr[i] & ~sw_rst);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sts_q <= IRQ_STS_RST;
        end else begin
            sts_q <= sts_d;
        end
    end

    always_comb begin
        irq_d = |(sts_q & ien_q[IRQ_LO_BIT +: IRQ_N]);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign irq = irq_q;

endmodule

/* File: gbx_peer.sv */
`timescale 1ns/1ns
module gbx_peer
    import gbx_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] ev,
    output gbx_pcs_s pcs
);
    gbx_pcs_s pcs_d;
    // Levels move once per request, pulses last one cycle like a real PCS
    always_comb begin
        pcs_d = pcs;
        pcs_d.speed = pcs.speed + 2'(ev[7]);
        pcs_d.duplex = pcs.duplex ^ ev[6];
        pcs_d.page_rx = ev[5];
        pcs_d.an_done = ev[4];
        if (ev[3]) begin
            pcs_d.link_up = 1'b0;
        end
        if (ev[2]) begin
            pcs_d.link_up = 1'b1;
        end
        pcs_d.sym_err = ev[1];
        pcs_d.false_carrier = ev[0];
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pcs <= '0;
        end else begin
            pcs <= pcs_d;
        end
    end
endmodule

/* File: gbx_serial_regs_properties.sv */
`timescale 1ns/1ns
module gbx_regs_chk
    import gbx_pkg::*;
#(
    parameter logic [17:0] LT_LONG_CYC = LT_1P6MS_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sw_rst,
    input wire gbx_pcs_s pcs,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire gbx_ctrl_s ctrl,
    input wire logic [17:0] link_timer_cyc
);
    logic [17:0] lt_exp;
    always_comb begin
        case (ctrl.timer_sel)
            LT_SEL_0P5US: lt_exp = 18'h3f;
            LT_SEL_1US: lt_exp = 18'h7d;
            LT_SEL_2US: lt_exp = 18'hfa;
            default: lt_exp = LT_LONG_CYC;
        endcase
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence sts_rd;
        psel && !penable && !pwrite && paddr == ADDR_IRQ_STS ##1 psel && penable;
    endsequence
    // Read straight after the event must already show it
    property ev_seen(ev, b);
        ev ##1 sts_rd |-> prdata[b];
    endproperty
    cap_read_a: assert property (psel && penable && !pwrite && paddr == ADDR_EXT_CAP
        |-> prdata == 32'h0000_8000) else $error("cap read wrong");
    timer_len_a: assert property ($stable(ctrl.timer_sel) |-> link_timer_cyc == lt_exp)
        else $error("link timer wrong");
    bypass_hold_a: assert property ($changed(ctrl.bypass_allow) |-> $past(sw_rst))
        else $error("bypass moved early");
    speed_seen_a: assert property (ev_seen($changed(pcs.speed), 14))
        else $error("speed lost");
    duplex_seen_a: assert property (ev_seen($changed(pcs.duplex), 13))
        else $error("duplex lost");
    loss_seen_a: assert property (ev_seen($fell(pcs.link_up), 10))
        else $error("link loss lost");
    gain_seen_a: assert property (ev_seen($rose(pcs.link_up), 9))
        else $error("link gain lost");
    symbol_seen_a: assert property (ev_seen(pcs.sym_err, 8))
        else $error("symbol error lost");
    page_seen_a: assert property (ev_seen(pcs.page_rx, 12))
        else $error("page received lost");
    done_seen_a: assert property (ev_seen(pcs.an_done, 11))
        else $error("negotiation done lost");
endmodule
bind gbx_serial_regs gbx_regs_chk #(.LT_LONG_CYC(LT_LONG_CYC)) chk_u (.clk, .rstn, .sw_rst,
    .pcs, .psel, .penable, .pwrite, .paddr, .prdata, .ctrl, .link_timer_cyc);

/* File: gbx_serial_regs_bench.sv */
`timescale 1ns/1ns
module gbx_serial_regs_bench;
    import gbx_pkg::*;
    localparam logic [17:0] LT = 18'h64;
    logic clk = 1'b0, rstn = 1'b1, sw_rst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic pready, pslverr, irq, er;
    logic [7:0] ev = '0;
    logic [17:0] link_timer_cyc;
    gbx_pcs_s pcs;
    gbx_ctrl_s ctrl;
    int err_count = 0;
    int tests_run = 0;
    `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
        $display("ERROR %0t got %h want %h", $time, g, e); end end
    always #4 clk = ~clk;
    gbx_peer peer_u (.clk, .rstn, .ev, .pcs);
    gbx_serial_regs #(.LT_LONG_CYC(LT)) dut_u (.clk, .rstn, .sw_rst, .pcs, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ctrl, .link_timer_cyc, .irq);
    task automatic wrap_up();
        if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            wrap_up();
        end
    endtask
    task automatic t_reset();
        xfer(1'b1, ADDR_EXT_CAP, 16'hffff);
        xfer(1'b0, ADDR_EXT_CAP, 16'h0);
        `CHK(rd, 32'h0000_8000)
        xfer(1'b0, ADDR_TMR_MODE, 16'h0);
        `CHK(rd, 32'h0000_2000)
        xfer(1'b0, ADDR_IRQ_EN, 16'h0);
        `CHK(rd, 32'h0)
        xfer(1'b0, 32'h0000_0100, 16'h0);
        `CHK({er, rd}, 33'h1_0000_0000)
    endtask
    task automatic t_timer();
        logic [17:0] lt [4];
        lt = '{LT, 18'h3f, 18'h7d, 18'hfa};
        for (int s = 0; s < 4; s++) begin
            xfer(1'b1, ADDR_TMR_MODE, {s[1:0], 14'h2001});
            repeat (2) @(negedge clk);
            `CHK(link_timer_cyc, lt[s])
            `CHK(ctrl.timer_sel, s[1:0])
            `CHK(ctrl.noise_filter, 1'b1)
        end
    endtask
    task automatic t_irq();
        for (int i = 0; i < 8; i++) begin
            // Bit 7 masked on the first pass only
            xfer(1'b1, ADDR_IRQ_EN, (i != 0) ? 16'h7f80 : 16'h7f00);
            @(posedge clk);
            ev <= 8'h1 << i;
            @(posedge clk);
            ev <= 8'h0;
            xfer(1'b0, ADDR_IRQ_STS, 16'h0);
            `CHK(rd, 32'h1 << (7 + i))
            @(negedge clk);
            `CHK(irq, i != 0)
            @(negedge clk);
            `CHK(irq, 1'b0)
            xfer(1'b0, ADDR_IRQ_STS, 16'h0);
            `CHK(rd, 32'h0)
        end
    endtask
    task automatic t_bypass();
        xfer(1'b1, ADDR_TMR_MODE, 16'h0002);
        `CHK(ctrl.bypass_allow, 1'b1)
        // Symbol error lands in the software reset cycle, so the set must win
        ev <= 8'h02;
        @(posedge clk);
        ev <= 8'h00;
        sw_rst <= 1'b1;
        @(posedge clk);
        sw_rst <= 1'b0;
        @(negedge clk);
        `CHK(ctrl.bypass_allow, 1'b0)
        xfer(1'b0, ADDR_IRQ_STS, 16'h0);
        `CHK(rd, 32'h0000_0100)
        // Event first, then a quiet software reset clears the status
        @(posedge clk);
        ev <= 8'h02;
        @(posedge clk);
        ev <= 8'h00;
        @(posedge clk);
        sw_rst <= 1'b1;
        @(posedge clk);
        sw_rst <= 1'b0;
        xfer(1'b0, ADDR_IRQ_STS, 16'h0);
        `CHK(rd, 32'h0)
        xfer(1'b0, ADDR_TMR_MODE, 16'h0);
        `CHK(rd, 32'h2)
        xfer(1'b0, ADDR_IRQ_EN, 16'h0);
        `CHK(rd, 32'h7f80)
    endtask
    initial begin
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_timer();
        t_irq();
        t_bypass();
        wrap_up();
    end
endmodule
